// *** dv/smcs_monitor.sv ***
// Checker for smcs_top, attached by bind from the bench.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module smcs_monitor (
    // Clock, reset and bus
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    // Pins and modes
    input wire logic boot_jump_fuse,
    input wire logic [1:0] power_mode,
    input wire logic [31:0] port_latch,
    input wire logic [31:0] port_pins,
    // Clock, boot mapping and reset vector outputs
    input wire logic cpu_tick,
    input wire logic [5:0] periph_fast,
    input wire logic double_speed_active,
    input wire logic boot_map_enable,
    input wire logic [15:0] reset_vector
);
    int gap;
    logic clean;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Spacing is only trusted when ce and the speed stayed put since the last tick
    always_ff @(posedge core_clk) begin
        gap <= cpu_tick ? 0 : gap + 1;
        clean <= !srst && ce && (cpu_tick || clean) && !$changed(double_speed_active);
    end
    sequence s_set_double;
        ce && sfr_wr && sfr_addr == 8'h8f && sfr_wdata[0];
    endsequence
    // The finished period ran on the speed seen one edge before the tick shows
    a_cpu_slow_gap: assert property (cpu_tick && clean && !$past(double_speed_active) |-> gap == 11)
        else $error("cpu tick gap wrong in standard speed");
    a_cpu_fast_gap: assert property (cpu_tick && clean && $past(double_speed_active) |-> gap == 5)
        else $error("cpu tick gap wrong in double speed");
    a_fast_needs_double: assert property (!double_speed_active |-> periph_fast == 6'h00)
        else $error("peripheral fast without double speed");
    a_double_follows_write: assert property (s_set_double |-> ##[1:4] double_speed_active)
        else $error("double speed not applied");
    a_pins_hold_data: assert property (power_mode == 2'h1 || power_mode == 2'h2 |=> port_pins == $past(port_latch))
        else $error("pins lost latch data");
    a_reset_pins_high: assert property ($fell(srst) |-> port_pins == 32'hffffffff)
        else $error("pins not high from reset");
    a_reset_clears: assert property ($fell(srst) |-> !double_speed_active && !cpu_tick && periph_fast == 6'h00)
        else $error("reset left speed state");
    a_boot_from_fuse: assert property ($fell(srst) |-> boot_map_enable == $past(boot_jump_fuse))
        else $error("boot mapping not loaded from fuse");
    a_vector_zero: assert property (reset_vector == 16'h0000)
        else $error("reset vector not zero");
endmodule

// *** dv/test_speed_mode_clock_select.sv ***
// Self-checking bench for smcs_top with random control values.
// Assumes smcs_pkg and smcs_monitor are compiled first.
`timescale 1ns/100ps
module test_speed_mode_clock_select;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic boot_jump_fuse = 1'b1;
    logic [1:0] power_mode = 2'h0;
    logic [31:0] port_latch = 32'h00000000;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic [31:0] port_pins;
    logic cpu_tick;
    logic [5:0] periph_tick;
    logic [5:0] periph_fast;
    logic double_speed_active;
    logic boot_map_enable;
    logic [15:0] reset_vector;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] d;
    logic [7:0] v;
    always #12.5 core_clk = ~core_clk;
    smcs_top uut (.core_clk, .srst, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
        .boot_jump_fuse, .power_mode, .port_latch, .port_pins, .cpu_tick, .periph_tick, .periph_fast,
        .double_speed_active, .boot_map_enable, .reset_vector);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = w;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] r);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        r = sfr_rdata;
    endtask
    function automatic logic tk(input int s);
        return s == 6 ? cpu_tick : periph_tick[s];
    endfunction
    // First loop aligns on a tick, second counts one full period
    task gap(input int s, input int exp);
        int n;
        repeat (2) begin
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (tk(s) !== 1'b1 && n < 40);
        end
        chk(n, exp);
    endtask
    function automatic int exp_gap(input logic [7:0] c, input int s);
        return (c[0] && (s == 6 || !c[s+1])) ? smcs_pkg::FAST_PERIODS : smcs_pkg::SLOW_PERIODS;
    endfunction
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            print_verdict;
        end
    end
    initial begin
        void'($urandom(32'hf6f9));
        // Power-up reset held for 24 oscillator periods, as a supervisor would
        repeat (24) @(negedge core_clk);
        chk(port_pins, 32'hffffffff);
        srst = 1'b0;
        rd(8'h8f, v);
        chk(v, 8'h00);
        chk(sfr_hit, 1'b1);
        rd(8'ha2, v);
        chk(v & 8'h08, 8'h08);
        rd(8'h90, v);
        chk(v, 8'h00);
        chk(sfr_hit, 1'b0);
        // Software may unmap the boot area; other bits read zero
        wr(8'ha2, 8'hf7);
        rd(8'ha2, v);
        chk(v, 8'h00);
        for (int i = 0; i < 14; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            wr(8'h8f, d);
            rd(8'h8f, v);
            chk(v, d & 8'h7f);
            chk(periph_fast, d[0] ? 6'(~d[6:1]) : 6'h00);
            chk(double_speed_active, d[0]);
        end
        foreach (v[i]) begin
            d = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h01 : 8'h7f;
            wr(8'h8f, d);
            for (int s = 0; s < 7; s++) gap(s, exp_gap(d, s));
        end
        for (int m = 1; m < 3; m++) begin
            power_mode = 2'(m);
            ce = m[0];
            port_latch = $urandom;
            repeat (2) @(negedge core_clk);
            chk(port_pins, port_latch);
        end
        power_mode = 2'h0;
        ce = 1'b1;
        // Map the boot area by software so the reset below must reload it
        wr(8'ha2, 8'h08);
        rd(8'ha2, v);
        chk(v, 8'h08);
        srst = 1'b1;
        boot_jump_fuse = 1'b0;
        repeat (24) @(negedge core_clk);
        chk(port_pins, 32'hffffffff);
        srst = 1'b0;
        rd(8'h8f, v);
        chk(v, 8'h00);
        rd(8'ha2, v);
        chk(v & 8'h08, 8'h00);
        chk(reset_vector, 16'h0000);
        print_verdict;
    end
endmodule
bind smcs_top smcs_monitor mon (.core_clk, .srst, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .boot_jump_fuse, .power_mode,
    .port_latch, .port_pins, .cpu_tick, .periph_fast, .double_speed_active, .boot_map_enable, .reset_vector);

// *** src/smcs_pkg.sv ***
// Constants for the speed mode clock select block.
// Assumes an 8-bit special-function bus driven by the CPU core.
package smcs_pkg;
    // ********************
    // Register map
    // ********************
    localparam logic [7:0] CLOCK_SPEED_CONTROL_ADDR = 8'h8f;
    localparam logic [7:0] AUX_CONTROL_ONE_ADDR = 8'ha2;
    localparam logic [7:0] CLOCK_SPEED_CONTROL_RST = 8'h00;
    localparam logic [7:0] CLOCK_SPEED_CONTROL_MASK = 8'h7f;
    // ********************
    // Field positions
    // ********************
    localparam int DOUBLE_SPEED_BIT = 0;
    localparam int TIMER_ZERO_BIT = 1;
    localparam int WATCHDOG_BIT = 6;
    localparam int BOOT_MAP_BIT = 3;
    localparam int NUM_PERIPH = 6;
    // ********************
    // Timing
    // ********************
    localparam int FAST_PERIODS = 6;
    localparam int SLOW_PERIODS = 12;
    localparam int MIN_RESET_OSC_PERIODS = 24;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [7:0] PORT_RESET_LEVEL = 8'hff;
    // ********************
    // Port modes
    // ********************
    typedef enum logic [1:0] {
        SMCS_RUN = 2'b00,
        SMCS_IDLE = 2'b01,
        SMCS_POWER_DOWN = 2'b10
    } smcs_mode_t;
endpackage

// *** src/smcs_tick_gen.sv ***
// Tick generator: one pulse every FAST or SLOW oscillator periods.
// Assumes the oscillator is core_clk and ce freezes the count.
`timescale 1ns/100ps
module smcs_tick_gen #(
    parameter int SLOW = smcs_pkg::SLOW_PERIODS,
    parameter int FAST = smcs_pkg::FAST_PERIODS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // Control
    input wire logic fast,
    // Output
    output logic tick
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic next_tick;

    // The 5-bit counter counts 0 to 31; periods above 31 are refused
    if (FAST < 1 || SLOW < FAST || SLOW > 31) begin : g_bad_periods
        $error("smcs_tick_gen: bad period counts");
    end

    always_comb begin
        next_count = count + 5'h01;
        next_tick = 1'b0;
        // Compare against the terminal count of the selected rate
        if (count >= (fast ? 5'(FAST - 1) : 5'(SLOW - 1))) begin
            next_count = 5'h00;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            count <= 5'h00;
            tick <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

// *** src/smcs_top.sv ***
// Speed mode clock select: clock control register, CPU and peripheral
// cycle ticks, reset state, boot mapping and port pin levels.
// Assumes the core drives a synchronous special-function bus on core_clk.
//
// Functional notes
// - Peripheral bit clear gives 6, set 12
// - Peripheral bits count only with double speed
// - Reset clears all clock speed control bits
// - Double speed halves peripheral time reference
// - Reset starts fetching at address zero
// - Idle and power-down keep port latch data
// - Reset loads boot mapping from fuse
// - CPU uses 12 periods, 6 in double
// - Double speed changes on halved clock edge
`timescale 1ns/100ps
module smcs_top (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // Special-function bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Boot fuse and power mode
    input wire logic boot_jump_fuse,
    input wire logic [1:0] power_mode,
    // Port latches and pins
    input wire logic [31:0] port_latch,
    output logic [31:0] port_pins,
    // Clock, boot mapping and reset vector outputs
    output logic cpu_tick,
    output logic [5:0] periph_tick,
    output logic [5:0] periph_fast,
    output logic double_speed_active,
    output logic boot_map_enable,
    output logic [15:0] reset_vector
);
    // ********************
    // Register file
    // ********************
    logic [7:0] clock_speed_control;
    logic [7:0] next_clock_speed_control;
    logic next_boot_map_enable;
    logic [7:0] next_sfr_rdata;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] base);
        sel = (a == base);
    endfunction

    always_comb begin
        next_clock_speed_control = clock_speed_control;
        next_boot_map_enable = boot_map_enable;
        if (sfr_wr && sel(sfr_addr, smcs_pkg::CLOCK_SPEED_CONTROL_ADDR)) begin
            // Bit 7 is reserved and never stored
            next_clock_speed_control = sfr_wdata & smcs_pkg::CLOCK_SPEED_CONTROL_MASK;
        end
        if (sfr_wr && sel(sfr_addr, smcs_pkg::AUX_CONTROL_ONE_ADDR)) begin
            next_boot_map_enable = sfr_wdata[smcs_pkg::BOOT_MAP_BIT];
        end
        next_sfr_rdata = 8'h00;
        if (sel(sfr_addr, smcs_pkg::CLOCK_SPEED_CONTROL_ADDR)) begin
            next_sfr_rdata = clock_speed_control;
        end else if (sel(sfr_addr, smcs_pkg::AUX_CONTROL_ONE_ADDR)) begin
            next_sfr_rdata[smcs_pkg::BOOT_MAP_BIT] = boot_map_enable;
        end
    end

    assign sfr_hit = sel(sfr_addr, smcs_pkg::CLOCK_SPEED_CONTROL_ADDR) ||
        sel(sfr_addr, smcs_pkg::AUX_CONTROL_ONE_ADDR);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            clock_speed_control <= smcs_pkg::CLOCK_SPEED_CONTROL_RST;
            // Fuse level caught by the clocked reset, not asynchronously
            boot_map_enable <= boot_jump_fuse;
            sfr_rdata <= 8'h00;
        end else if (ce) begin
            clock_speed_control <= next_clock_speed_control;
            boot_map_enable <= next_boot_map_enable;
            sfr_rdata <= sfr_rd ? next_sfr_rdata : sfr_rdata;
        end
    end

    // ********************
    // Glitch-free double speed switch
    // ********************
    logic half_clk;
    logic next_half_clk;
    logic next_double_speed_active;

    always_comb begin
        next_half_clk = ~half_clk;
        next_double_speed_active = double_speed_active;
        // Take the new mode only where the halved clock rises
        if (!half_clk) begin
            next_double_speed_active = clock_speed_control[smcs_pkg::DOUBLE_SPEED_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            half_clk <= 1'b0;
            double_speed_active <= 1'b0;
        end else if (ce) begin
            half_clk <= next_half_clk;
            double_speed_active <= next_double_speed_active;
        end
    end

    // ********************
    // CPU and peripheral cycle ticks
    // ********************
    // Reset restarts all dividers, so the first CPU cycle starts at the vector
    smcs_tick_gen #(
        .SLOW(smcs_pkg::SLOW_PERIODS),
        .FAST(smcs_pkg::FAST_PERIODS)
    ) u_cpu_tick (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .fast(double_speed_active),
        .tick(cpu_tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < smcs_pkg::NUM_PERIPH; gi++) begin : g_periph
            // A set bit keeps the peripheral at standard rate
            assign periph_fast[gi] = double_speed_active &&
                !clock_speed_control[smcs_pkg::TIMER_ZERO_BIT + gi];
            smcs_tick_gen #(
                .SLOW(smcs_pkg::SLOW_PERIODS),
                .FAST(smcs_pkg::FAST_PERIODS)
            ) u_tick (
                .core_clk(core_clk),
                .srst(srst),
                .ce(ce),
                .fast(periph_fast[gi]),
                .tick(periph_tick[gi])
            );
        end
    endgenerate

    assign reset_vector = smcs_pkg::RESET_VECTOR;

    // ********************
    // Port pins
    // ********************
    logic [31:0] next_port_pins;

    always_comb begin
        // Idle and power-down always show the latch data; run shows it only while ce is high
        next_port_pins = port_latch;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            port_pins <= {4{smcs_pkg::PORT_RESET_LEVEL}};
        end else if (ce || power_mode != 2'(smcs_pkg::SMCS_RUN)) begin
            port_pins <= next_port_pins;
        end
    end
endmodule
